// ### hdl/irq_status_regulator.sv
// Purpose: interrupt status, mask and regulator decode behind axi4-lite
// Assumes: event inputs synchronous to aclk, one-cycle pulses
// Notes: reading the status word clears the bits it returned and drops irq
//
// Contract
// [R1] status clears on reset, enable low, protocol write
// [R2] read completion clears status and irq; code clears one edge after the read address is taken, rready or not
// [R3] host reads status to clear it
// [R4] tx flag at start, irq at end
// [R5] rx flag at sof, irq at end
// [R6] fifo flag outside one third band
// [R7] reader crc flag unless crc disabled
// [R8] reader parity bit3, framing bit2
// [R9] collision when pulses exceed 6 or 7
// [R10] reader no-response sets bit0
// [R11] during tx only bits 5,7 change
// [R12] during rx only bit6, irq deferred
// [R13] nfc bit4 any protocol error
// [R14] nfc bit3 sdd completed
// [R15] nfc bit2 field level crossed
// [R16] nfc bit1 collision avoidance done
// [R17] nfc bit0 collision avoidance failed
// [R18] chip bit0 selects 5v or 3v
// [R19] manual 3v: 2.7 to 3.4 volts
// [R20] auto: headroom 250, 350, 400 mv
// [R21] mask gates bits 5..0, noresp off
// [R22] event during clearing read is kept
`timescale 1ns/1ps
`include "irq_status_regulator_cfg.svh"

module irq_status_regulator (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_enable,
    // axi4-lite write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transceiver side
    input irq_status_regulator_pkg::link_events_t events,
    input wire logic [7:0] fifo_level,
    output logic irq,
    output logic decoder_enable,
    output irq_status_regulator_pkg::regulator_t regulator
);
    import irq_status_regulator_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[9:2];
    endfunction

    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        lane_merge = s[0] ? d[7:0] : old;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] chip_status_r, chip_status_nxt;
    logic [7:0] protocol_r, protocol_nxt;
    logic [7:0] regulator_io_r, regulator_io_nxt;
    logic [7:0] status_r, status_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic irq_r, irq_nxt;
    phase_t phase_r, phase_nxt;
    logic [2:0] pulse_cnt_r, pulse_cnt_nxt;
    logic [1:0] fifo_out_r, fifo_out_nxt;
    logic [7:0] pend_r, pend_nxt;

    logic aw_hold_r, aw_hold_nxt;
    logic [31:0] awaddr_r, awaddr_nxt;
    logic w_hold_r, w_hold_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic rd_clear_r, rd_clear_nxt;

    logic do_write;
    logic [7:0] widx;
    logic nfc_mode;
    logic [7:0] set_bits;
    logic [7:0] irq_bits;
    logic [2:0] col_limit;

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    assign s_axi_awready = ~aw_hold_r;
    assign s_axi_wready = ~w_hold_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
    assign widx = word_index(awaddr_r);

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        awaddr_nxt = awaddr_r;
        w_hold_nxt = w_hold_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        rd_clear_nxt = 1'b0;
        if (s_axi_awvalid && !aw_hold_r) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_r) begin
            w_hold_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            case (widx)
                `IDX_CHIP_STATUS, `IDX_PROTOCOL_SELECT, `IDX_REGULATOR_IO,
                `IDX_INTERRUPT_MASK, `IDX_INTERRUPT_STATUS: bresp_nxt = 2'h0;
                default: bresp_nxt = 2'h2;
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = 2'h0;
            rdata_nxt = 32'h0000_0000;
            case (word_index(s_axi_araddr))
                `IDX_CHIP_STATUS: rdata_nxt[7:0] = chip_status_r;
                `IDX_PROTOCOL_SELECT: rdata_nxt[7:0] = protocol_r;
                `IDX_REGULATOR_IO: rdata_nxt[7:0] = regulator_io_r;
                `IDX_INTERRUPT_MASK: rdata_nxt[7:0] = mask_r;
                `IDX_INTERRUPT_STATUS: begin
                    rdata_nxt[7:0] = status_r;
                    // clear lands one edge after the address is taken, even with rready still low
                    rd_clear_nxt = 1'b1;
                end
                default: rresp_nxt = 2'h2;
            endcase
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_comb begin
        chip_status_nxt = chip_status_r;
        protocol_nxt = protocol_r;
        regulator_io_nxt = regulator_io_r;
        mask_nxt = mask_r;
        if (do_write) begin
            case (widx)
                `IDX_CHIP_STATUS: chip_status_nxt = lane_merge(chip_status_r, wdata_r, wstrb_r);
                `IDX_PROTOCOL_SELECT: protocol_nxt = lane_merge(protocol_r, wdata_r, wstrb_r);
                `IDX_REGULATOR_IO: regulator_io_nxt = lane_merge(regulator_io_r, wdata_r, wstrb_r);
                `IDX_INTERRUPT_MASK: mask_nxt = lane_merge(mask_r, wdata_r, wstrb_r);
                default: mask_nxt = mask_r;
            endcase
        end
    end

    // ----------------------------------------
    // phase and event decode
    // ----------------------------------------
    assign nfc_mode = protocol_r[`BIT_NFC_MODE];
    // [R9] six or seven pulse limit
    assign col_limit = mask_r[`BIT_COL_6] ? 3'd6 : 3'd7;
    // [R11] decoder off while sending
    assign decoder_enable = (phase_r != PH_TX);

    always_comb begin
        phase_nxt = phase_r;
        pulse_cnt_nxt = pulse_cnt_r;
        // high and low bands kept apart, so a jump from one to the other still flags
        fifo_out_nxt = {fifo_level > `FIFO_HIGH, fifo_level <= `FIFO_LOW};
        case (phase_r)
            PH_IDLE: begin
                if (events.tx_start) begin
                    phase_nxt = PH_TX;
                end else if (events.rx_sof) begin
                    phase_nxt = PH_RX;
                end
            end
            PH_TX: begin
                if (events.tx_end) begin
                    phase_nxt = PH_IDLE;
                end
            end
            PH_RX: begin
                if (events.rx_end) begin
                    phase_nxt = PH_IDLE;
                end
            end
            default: phase_nxt = PH_IDLE;
        endcase
        if (events.bit_period_end || phase_r != PH_RX) begin
            pulse_cnt_nxt = 3'd0;
        end else if (events.subcarrier_pulse && pulse_cnt_r != 3'd7) begin
            pulse_cnt_nxt = pulse_cnt_r + 3'd1;
        end
    end

    always_comb begin
        set_bits = 8'h00;
        // [R4] tx flag at start
        set_bits[`BIT_TX] = events.tx_start;
        // [R5] rx flag at start of frame
        set_bits[`BIT_RX_START] = events.rx_sof;
        // [R6] fifo band edge
        set_bits[`BIT_FIFO] = |(fifo_out_nxt & ~fifo_out_r);
        if (phase_r == PH_TX) begin
            // [R11] only 5 and 7 may move
            set_bits[`BIT_RX_START] = 1'b0;
        end else if (phase_r == PH_RX) begin
            // [R12] only bit 6 may move
            set_bits[`BIT_TX] = 1'b0;
            set_bits[`BIT_FIFO] = 1'b0;
        end else if (nfc_mode) begin
            // [R13] any protocol error
            set_bits[`BIT_ERR_CRC] = events.crc_or_protocol_error_flag;
            // [R14] sdd completion
            set_bits[`BIT_ERR_PARITY] = events.sdd_done;
            // [R15] field crossing
            set_bits[`BIT_ERR_FRAMING] = events.field_change_flag;
            // [R16] avoidance finished
            set_bits[`BIT_COL] = events.cavoid_done;
            // [R17] avoidance failed
            set_bits[`BIT_NORESP] = events.cavoid_fail;
        end else begin
            // [R7] crc unless disabled
            set_bits[`BIT_ERR_CRC] = events.crc_or_protocol_error_flag & ~protocol_r[`BIT_NO_RX_CRC];
            // [R8] parity and framing
            set_bits[`BIT_ERR_PARITY] = events.parity_error_flag;
            set_bits[`BIT_ERR_FRAMING] = events.framing_eof_error_flag;
            // [R10] no-response
            set_bits[`BIT_NORESP] = events.no_response;
        end
        // [R9] collision count sits in rx
        if (!nfc_mode && phase_r == PH_RX && events.subcarrier_pulse && pulse_cnt_r >= col_limit) begin
            set_bits[`BIT_COL] = 1'b1;
        end
    end

    // [R21] mask covers bits 5..0
    assign irq_bits = set_bits & {2'b11, mask_r[5:0]};

    always_comb begin
        status_nxt = status_r;
        pend_nxt = pend_r | set_bits;
        irq_nxt = irq_r;
        // collision found inside rx is held until rx ends
        if (phase_r != PH_RX) begin
            status_nxt = status_r | pend_r | set_bits;
            pend_nxt = 8'h00;
        end else begin
            status_nxt = status_r | (set_bits & 8'h40);
            pend_nxt = pend_r | (set_bits & 8'hBF);
        end
        if (rd_clear_r) begin
            // [R2] read clears status and irq; [R22] same-cycle events kept
            // only the bits handed to the host go; a flag landing as the read was taken stays
            status_nxt = (status_r & ~rdata_r[7:0]) | (set_bits & ((phase_r == PH_RX) ? 8'h40 : 8'hFF));
            if (phase_r != PH_RX) begin
                status_nxt = status_nxt | pend_r;
            end
            irq_nxt = 1'b0;
        end
        // [R4] [R5] [R12] irq at phase end
        if ((phase_r == PH_TX && events.tx_end) || (phase_r == PH_RX && events.rx_end)) begin
            irq_nxt = 1'b1;
        end else if (phase_r == PH_IDLE && |(irq_bits & 8'h3F)) begin
            irq_nxt = 1'b1;
        end
        // [R1] protocol write clears
        if (do_write && widx == `IDX_PROTOCOL_SELECT) begin
            status_nxt = 8'h00;
            pend_nxt = 8'h00;
            irq_nxt = 1'b0;
        end
    end

    assign irq = irq_r;

    // ----------------------------------------
    // regulator decode
    // ----------------------------------------
    always_comb begin
        regulator.auto_mode = regulator_io_r[`BIT_AUTO_REG];
        regulator.rail_mv = 16'd0;
        regulator.headroom_mv = 16'd0;
        if (regulator_io_r[`BIT_AUTO_REG]) begin
            // [R20] bit 2 ignored
            case (regulator_io_r[1:0])
                2'b11: regulator.headroom_mv = `MV_HEAD_250;
                2'b10: regulator.headroom_mv = `MV_HEAD_350;
                default: regulator.headroom_mv = `MV_HEAD_400;
            endcase
        end else if (chip_status_r[`BIT_SUPPLY_5V]) begin
            // [R18] 5v system steps
            regulator.rail_mv = `MV_5V_BASE + `MV_STEP * {13'd0, regulator_io_r[2:0]};
        end else begin
            // [R19] 3v system steps
            regulator.rail_mv = `MV_3V_BASE + `MV_STEP * {13'd0, regulator_io_r[2:0]};
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !chip_enable) begin
            // [R1] cleared at power-on and enable low
            chip_status_r <= `RST_CHIP_STATUS;
            protocol_r <= `RST_PROTOCOL_SELECT;
            regulator_io_r <= `RST_REGULATOR_IO;
            status_r <= `RST_INTERRUPT_STATUS;
            mask_r <= `RST_INTERRUPT_MASK;
            irq_r <= 1'b0;
            phase_r <= PH_IDLE;
            pulse_cnt_r <= 3'd0;
            fifo_out_r <= 2'b00;
            pend_r <= 8'h00;
        end else begin
            chip_status_r <= chip_status_nxt;
            protocol_r <= protocol_nxt;
            regulator_io_r <= regulator_io_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
            phase_r <= phase_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            fifo_out_r <= fifo_out_nxt;
            pend_r <= pend_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            w_hold_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
            rd_clear_r <= 1'b0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            awaddr_r <= awaddr_nxt;
            w_hold_r <= w_hold_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            rd_clear_r <= rd_clear_nxt;
        end
    end

endmodule

// ### shared/irq_status_regulator_cfg.svh
// Purpose: offsets, field positions, reset values of the irq status block
// Assumes: 32-bit axi4-lite word per register
// Notes: byte address is four times the register index
`ifndef IRQ_STATUS_REGULATOR_CFG_SVH
`define IRQ_STATUS_REGULATOR_CFG_SVH

// ----------------------------------------
// register indices and address width
// ----------------------------------------
`define IDX_CHIP_STATUS 8'h00
`define IDX_PROTOCOL_SELECT 8'h01
`define IDX_REGULATOR_IO 8'h0B
`define IDX_INTERRUPT_STATUS 8'h0C
`define IDX_INTERRUPT_MASK 8'h0E
`define IDX_EVENT_INPUT 8'h20
`define ADDR_W 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CHIP_STATUS 8'h00
`define RST_PROTOCOL_SELECT 8'h00
`define RST_REGULATOR_IO 8'h87
`define RST_INTERRUPT_STATUS 8'h00
`define RST_INTERRUPT_MASK 8'h3E

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_TX 7
`define BIT_RX_START 6
`define BIT_FIFO 5
`define BIT_ERR_CRC 4
`define BIT_ERR_PARITY 3
`define BIT_ERR_FRAMING 2
`define BIT_COL 1
`define BIT_NORESP 0
`define BIT_SUPPLY_5V 0
`define BIT_NO_RX_CRC 7
`define BIT_NFC_MODE 5
`define BIT_AUTO_REG 7
`define BIT_COL_6 6

// ----------------------------------------
// regulator encodings in millivolts, fifo depth and thresholds
// ----------------------------------------
`define MV_3V_BASE 16'd2700
`define MV_5V_BASE 16'd4300
`define MV_STEP 16'd100
`define MV_HEAD_250 16'd250
`define MV_HEAD_350 16'd350
`define MV_HEAD_400 16'd400
`define FIFO_DEPTH 8'd128
`define FIFO_LOW 8'd42
`define FIFO_HIGH 8'd85

`endif

// ### shared/irq_status_regulator_pkg.sv
// Purpose: types shared by the irq status block
// Assumes: nothing beyond the cfg header
// Notes: events travel as one packed struct
package irq_status_regulator_pkg;

    typedef struct packed {
        logic tx_start;
        logic tx_end;
        logic rx_sof;
        logic rx_end;
        logic crc_or_protocol_error_flag;
        logic parity_error_flag;
        logic framing_eof_error_flag;
        logic subcarrier_pulse;
        logic bit_period_end;
        logic no_response;
        logic sdd_done;
        logic field_change_flag;
        logic cavoid_done;
        logic cavoid_fail;
    } link_events_t;

    typedef struct packed {
        logic [15:0] rail_mv;
        logic [15:0] headroom_mv;
        logic auto_mode;
    } regulator_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_TX,
        PH_RX
    } phase_t;

endpackage

// ### sim/irq_status_checker.sv
// Purpose: port-level assertions for the irq status block
// Assumes: byte address is four times the register index
// Notes: read address is tracked here, the block hides it
`timescale 1ns/1ps

module irq_status_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_enable,
    // bus
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transceiver side
    input irq_status_regulator_pkg::link_events_t events,
    input wire logic irq,
    input wire logic decoder_enable,
    input irq_status_regulator_pkg::regulator_t regulator
);
    import irq_status_regulator_pkg::*;
    logic [7:0] rd_a_r;
    logic [7:0] rd_a_nxt;

    always_comb rd_a_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr[7:0] : rd_a_r;
    always_ff @(posedge aclk) rd_a_r <= rd_a_nxt;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // --------------------------------
    // status and interrupt
    // --------------------------------
    sequence s_rd_status;
        s_axi_rvalid && s_axi_rready && rd_a_r == 8'h30 && events == '0;
    endsequence
    sequence s_tx_done;
        !decoder_enable && events.tx_end && chip_enable;
    endsequence
    property p_rd_clear; s_rd_status |=> !irq; endproperty
    property p_en_low; !chip_enable |=> !irq; endproperty
    property p_tx_dec; chip_enable && events.tx_start |=> !decoder_enable; endproperty
    property p_tx_irq; s_tx_done |=> irq && decoder_enable; endproperty
    property p_rx_quiet; decoder_enable && events.rx_sof && !irq |=> !irq [*2]; endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("irq held after status read");
    a_en_low: assert property (p_en_low) else $error("irq held with enable low");
    a_tx_dec: assert property (p_tx_dec) else $error("decoder on during transmit");
    a_tx_irq: assert property (p_tx_irq) else $error("no irq at transmit end");
    a_rx_quiet: assert property (p_rx_quiet) else $error("irq at receive start");

    // --------------------------------
    // bus and regulator decode
    // --------------------------------
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_unmapped; s_axi_rvalid && rd_a_r == 8'h3C |-> s_axi_rresp == 2'b10 && s_axi_rdata == '0; endproperty
    property p_head; regulator.auto_mode |-> regulator.headroom_mv inside {16'd250, 16'd350, 16'd400}; endproperty
    property p_rail;
        !regulator.auto_mode |-> regulator.rail_mv inside {[16'd2700:16'd3400], [16'd4300:16'd5000]};
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_head: assert property (p_head) else $error("headroom out of set");
    a_rail: assert property (p_rail) else $error("rail out of range");
endmodule

bind irq_status_regulator irq_status_checker chk (.*);

// ### sim/link_model.sv
// Purpose: transceiver-side event source facing the status block
// Assumes: one event pulse per request from the bench
// Notes: pulses last one cycle, as the framing core gives them
`timescale 1ns/1ps

module link_model (
    // clock
    input wire logic aclk,
    // request from the bench
    input wire logic go,
    input wire logic [3:0] idx,
    input wire logic [7:0] level,
    // toward the block
    output irq_status_regulator_pkg::link_events_t events,
    output logic [7:0] fifo_level
);
    import irq_status_regulator_pkg::*;

    // --------------------------------
    // event pulses
    // --------------------------------
    always_ff @(posedge aclk) begin
        events <= link_events_t'(go ? 14'h0001 << idx : 14'h0000);
        fifo_level <= level;
    end
endmodule

// ### sim/test_irq_status_regulator_cfg.sv
// Purpose: self-checking bench for the irq status block
// Assumes: status at byte 0x30, regulator 0x2C, mask 0x38
// Notes: events come from link_model, registers over axi4-lite
`timescale 1ns/1ps
`include "irq_status_regulator_cfg.svh"

module test_irq_status_regulator_cfg;
    import irq_status_regulator_pkg::*;
    logic aclk;
    logic aresetn = 1'b0;
    logic chip_enable = 1'b1;
    logic [31:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    link_events_t events;
    logic [7:0] fifo_level;
    logic irq;
    logic decoder_enable;
    regulator_t regulator;
    logic go = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [7:0] level = 8'h40;
    int error_cnt = 0;
    int checks = 0;
    int seed = 39;
    logic [7:0] prot [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h80};
    logic [3:0] evi [10] = '{4'h9, 4'h8, 4'h7, 4'h4, 4'h9, 4'h3, 4'h2, 4'h1, 4'h0, 4'h9};
    logic [7:0] exs [10] = '{8'h10, 8'h08, 8'h04, 8'h01, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};

    irq_status_regulator dut (.*);
    link_model far (.*);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // --------------------------------
    // compare, bus and event tasks
    // --------------------------------
    task automatic cmp_val(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_bit(input string n, input logic e, input logic g);
        cmp_val(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        cmp_val("bresp", a == 8'h3C ? 32'h2 : 32'h0, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        cmp_val("rdata", {24'h0, e}, s_axi_rdata);
        cmp_val("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // three extra edges so the flag update has landed
    task automatic fire(input logic [3:0] i);
        idx <= i;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    function automatic logic [15:0] exp_mv(input logic s5, input logic [7:0] v);
        if (v[7]) return v[1:0] == 2'h3 ? 16'd250 : (v[1:0] == 2'h2 ? 16'd350 : 16'd400);
        return (s5 ? 16'd4300 : 16'd2700) + 16'd100 * v[2:0];
    endfunction
    task automatic stop_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        stop_test();
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        logic [7:0] v;
        logic [7:0] s;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 8'h00, 2'h0);
        rd(8'h2C, 8'h87, 2'h0);
        rd(8'h30, 8'h00, 2'h0);
        rd(8'h38, 8'h3E, 2'h0);
        rd(8'h3C, 8'h00, 2'h2);
        wr(8'h3C, 8'h55);
        fire(4'h4);
        cmp_bit("irq noresp masked", 1'b0, irq);
        wr(8'h04, 8'h00);
        wr(8'h38, 8'h3F);
        for (int k = 0; k < 10; k++) begin
            wr(8'h04, prot[k]);
            fire(evi[k]);
            cmp_bit("irq set", exs[k] != 8'h00, irq);
            rd(8'h30, exs[k], 2'h0);
            cmp_bit("irq after read", 1'b0, irq);
        end
        wr(8'h04, 8'h00);
        fire(4'h9);
        wr(8'h04, 8'h00);
        cmp_bit("irq protocol write", 1'b0, irq);
        rd(8'h30, 8'h00, 2'h0);
        // crc flag lands in the edge that takes the status read
        idx <= 4'h9;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        rd(8'h30, 8'h00, 2'h0);
        rd(8'h30, 8'h10, 2'h0);
        fire(4'hD);
        cmp_bit("decoder in tx", 1'b0, decoder_enable);
        fire(4'h8);
        level <= 8'd20;
        repeat (3) @(posedge aclk);
        cmp_bit("irq in tx", 1'b0, irq);
        fire(4'hC);
        cmp_bit("irq tx end", 1'b1, irq);
        rd(8'h30, 8'hA0, 2'h0);
        level <= 8'd100;
        repeat (3) @(posedge aclk);
        rd(8'h30, 8'h20, 2'h0);
        level <= 8'd64;
        repeat (3) @(posedge aclk);
        // collision limit 7 by default, 6 with mask bit6
        for (int k = 0; k < 4; k++) begin
            wr(8'h38, k < 2 ? 8'h3F : 8'h7F);
            fire(4'hB);
            fire(4'h7);
            repeat (k == 3 ? 6 : 7 + (k == 1)) fire(4'h6);
            cmp_bit("irq in rx", 1'b0, irq);
            fire(4'h5);
            fire(4'hA);
            rd(8'h30, (k == 1 || k == 2) ? 8'h42 : 8'h40, 2'h0);
        end
        fire(4'h9);
        wr(8'h2C, 8'h05);
        chip_enable <= 1'b0;
        @(posedge aclk);
        chip_enable <= 1'b1;
        repeat (2) @(posedge aclk);
        cmp_bit("irq enable low", 1'b0, irq);
        rd(8'h30, 8'h00, 2'h0);
        rd(8'h2C, 8'h87, 2'h0);
        for (int k = 0; k < 12; k++) begin
            v = k == 0 ? 8'h00 : (k == 1 ? 8'h07 : (k == 2 ? 8'h83 : 8'($random(seed))));
            s = 8'($random(seed));
            wr(8'h00, {7'h0, s[0]});
            wr(8'h2C, v);
            if (v[7]) cmp_val("headroom", {16'h0, exp_mv(s[0], v)}, {16'h0, regulator.headroom_mv});
            else cmp_val("rail", {16'h0, exp_mv(s[0], v)}, {16'h0, regulator.rail_mv});
        end
        stop_test();
    end
endmodule
